/* File: irq_defines.vh */
/*
 * Register offsets, field positions, reset values and timing constants
 * for the shared-request and periodic interrupt block.
 * Assumes inclusion by the design file and its checker; definitions alone.
 */
`ifndef IRQ_DEFINES_VH
`define IRQ_DEFINES_VH

// Register byte offsets on the APB bus.
`define OFS_PERIOD_CTRL 12'h000
`define OFS_SRC_CTRL 12'h004
`define OFS_SHARED_CTRL 12'h008
`define OFS_CORE_CTRL 12'h00C
`define OFS_VECTOR 12'h010

// Period control fields.
`define PC_ON 7
`define PC_CLKSEL 6
`define PC_P1_HI 5
`define PC_P1_LO 4
`define PC_LOWPWR 3
`define PC_P0_HI 2
`define PC_P0_LO 0
`define PC_RESET 8'h37

// Source control fields: flags in 7..4, enables in 3..0.
`define SRC_EE_FLAG 7
`define SRC_LV_FLAG 6
`define SRC_XP_FLAG 5
`define SRC_SM_FLAG 4
`define SRC_EE_EN 3
`define SRC_LV_EN 2
`define SRC_XP_EN 1
`define SRC_SM_EN 0

// Shared control: flags 13..8, enables 5..0.
`define SH_FLAG_LO 8
`define SH_EN_LO 0

// Core control fields.
`define CC_GIE 0
`define CC_P0_EN 1
`define CC_P1_EN 2
`define CC_P0_FLAG 3
`define CC_P1_FLAG 4

// Divider base lengths and prescale for the system clock path.
`define P0_BASE_LOG2 8
`define P1_BASE_LOG2 12
`define SYS_PRESCALE 2'h3

// Vector codes: 1..6 shared groups, 7 and 8 periodic.
`define VEC_NONE 4'h0
`define VEC_P0 4'h7
`define VEC_P1 4'h8

`endif

/* File: irq_block.v */
/*
 * Shared-request and periodic interrupt logic with an APB register slave.
 * Assumes pclk is the system clock; source events are one-cycle pulses in
 * the pclk domain except the peripheral pin and the dedicated period clock,
 * which are synchronised here.
 */
`timescale 1ns/1ps
`include "irq_defines.vh"

module irq_block (
  // APB slave.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Source events, one-cycle pulses on pclk except the peripheral pin and the dedicated period clock.
  input wire serial_byte_done,
  input wire eeprom_cycle_done,
  input wire low_voltage_event,
  input wire [5:0] timer_event,
  input wire periph_irq_pin,
  input wire dedicated_period_clock,
  // Processor core.
  input wire stack_full,
  input wire core_ack,
  input wire ret_from_irq,
  output reg irq_req,
  output reg [3:0] irq_vector,
  output reg slow_crystal_low_power
);

  reg [7:0] period_ctrl;
  reg serial_module_flag;
  reg ext_periph_flag;
  reg eeprom_done_flag;
  reg low_voltage_flag;
  reg serial_module_enable;
  reg ext_periph_enable;
  reg eeprom_done_enable;
  reg low_voltage_enable;
  reg [5:0] shared_request_flags;
  reg [5:0] shared_enable;
  reg global_irq_enable;
  reg period0_irq_enable;
  reg period1_irq_enable;
  reg period0_request_flag;
  reg period1_request_flag;
  reg [2:0] pin_sync;
  reg [2:0] tclk_sync;
  reg [1:0] prescale;
  reg [14:0] divider;
  reg [3:0] next_vector;

  wire wr = psel & penable & pwrite;
  wire rd_en = psel & ~pwrite;
  wire period_dividers_on = period_ctrl[`PC_ON];
  wire period_clock_select = period_ctrl[`PC_CLKSEL];
  wire [1:0] period1_length_sel = period_ctrl[`PC_P1_HI:`PC_P1_LO];
  wire [2:0] period0_length_sel = period_ctrl[`PC_P0_HI:`PC_P0_LO];

  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Returns high when the address matches a mapped register.
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `OFS_PERIOD_CTRL) || (a == `OFS_SRC_CTRL) ||
               (a == `OFS_SHARED_CTRL) || (a == `OFS_CORE_CTRL) ||
               (a == `OFS_VECTOR);
    end
  endfunction

  // Returns high when the bus address selects the given register.
  function at_ofs;
    input [11:0] a;
    input [11:0] ofs;
    begin
      at_ofs = (a == ofs);
    end
  endfunction

  // Input pin edge and dedicated clock edge found on pclk.
  wire pin_fall = pin_sync[2] & ~pin_sync[1];
  wire tclk_rise = tclk_sync[1] & ~tclk_sync[2];
  wire period_tick = period_clock_select ? (prescale == `SYS_PRESCALE)
                                         : tclk_rise;

  // The overflow of a bit of the free-running divider marks each period.
  wire [14:0] next_divider = divider + 15'h0001;
  wire [4:0] p0_bit = 5'd`P0_BASE_LOG2 - 5'd1 + {2'b00, period0_length_sel};
  wire [4:0] p1_bit = 5'd`P1_BASE_LOG2 - 5'd1 + {3'b000, period1_length_sel};
  wire p0_ovf = period_dividers_on & period_tick &
                divider[p0_bit[3:0]] & ~next_divider[p0_bit[3:0]];
  wire p1_ovf = period_dividers_on & period_tick &
                divider[p1_bit[3:0]] & ~next_divider[p1_bit[3:0]];

  // Source events fanned into the shared groups: group 0 takes the enabled serial,
  // peripheral, low voltage and EEPROM events; groups 1 to 5 take timer events 1 to 5.
  wire [5:0] group_event;
  wire src_sm_set = serial_byte_done;
  wire src_xp_set = pin_fall & ext_periph_enable;
  wire src_ee_set = eeprom_cycle_done;
  wire src_lv_set = low_voltage_event;
  assign group_event[0] = (src_sm_set & serial_module_enable) |
                          src_xp_set |
                          (src_ee_set & eeprom_done_enable) |
                          (src_lv_set & low_voltage_enable);
  assign group_event[5:1] = timer_event[5:1];

  wire [5:0] shared_pend = shared_request_flags & shared_enable;
  wire ok_to_grant = global_irq_enable & ~stack_full & ~irq_req;

  // Fixed priority: shared groups first, then period 0, then period 1.
  always @* begin
    next_vector = `VEC_NONE;
    if (shared_pend[0]) begin
      next_vector = 4'h1;
    end else if (shared_pend[1]) begin
      next_vector = 4'h2;
    end else if (shared_pend[2]) begin
      next_vector = 4'h3;
    end else if (shared_pend[3]) begin
      next_vector = 4'h4;
    end else if (shared_pend[4]) begin
      next_vector = 4'h5;
    end else if (shared_pend[5]) begin
      next_vector = 4'h6;
    end else if (period0_request_flag & period0_irq_enable) begin
      next_vector = `VEC_P0;
    end else if (period1_request_flag & period1_irq_enable) begin
      next_vector = `VEC_P1;
    end
  end

  // Two flops settle each input; the third only serves edge detection.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync <= 3'h7;
      tclk_sync <= 3'h0;
    end else begin
      pin_sync <= {pin_sync[1:0], periph_irq_pin};
      tclk_sync <= {tclk_sync[1:0], dedicated_period_clock};
    end
  end

  // Free-running prescaler for the system clock over four.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale <= 2'h0;
    end else begin
      prescale <= prescale + 2'h1;
    end
  end

  // Held at zero while off, so every enable starts a full period.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider <= 15'h0000;
    end else if (!period_dividers_on) begin
      divider <= 15'h0000;
    end else if (period_tick) begin
      divider <= next_divider;
    end
  end

  // A grant is taken when the core acknowledges the standing request.
  // The clear it causes applies even if software writes the same register
  // in that cycle, so a serviced flag never survives to be taken twice.
  wire take = core_ack & irq_req;
  wire take_p0 = take & (irq_vector == `VEC_P0);
  wire take_p1 = take & (irq_vector == `VEC_P1);
  wire [5:0] shared_taken = (take && irq_vector < `VEC_P0) ?
                            (6'h01 << (irq_vector - 4'h1)) : 6'h00;
  wire wr_period = wr & at_ofs(paddr, `OFS_PERIOD_CTRL);
  wire wr_src = wr & at_ofs(paddr, `OFS_SRC_CTRL);
  wire wr_shared = wr & at_ofs(paddr, `OFS_SHARED_CTRL);
  wire wr_core = wr & at_ofs(paddr, `OFS_CORE_CTRL);

  // Period control and the registered copy of the low power bit.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_ctrl <= `PC_RESET;
      slow_crystal_low_power <= 1'b0;
    end else begin
      slow_crystal_low_power <= period_ctrl[`PC_LOWPWR];
      if (wr_period) begin
        period_ctrl <= pwdata[7:0];
      end
    end
  end

  // Source flags and enables; an event in the cycle of a clear wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_module_flag <= 1'b0;
      ext_periph_flag <= 1'b0;
      eeprom_done_flag <= 1'b0;
      low_voltage_flag <= 1'b0;
      serial_module_enable <= 1'b0;
      ext_periph_enable <= 1'b0;
      eeprom_done_enable <= 1'b0;
      low_voltage_enable <= 1'b0;
    end else if (wr_src) begin
      serial_module_flag <= pwdata[`SRC_SM_FLAG] | src_sm_set;
      ext_periph_flag <= pwdata[`SRC_XP_FLAG] | src_xp_set;
      eeprom_done_flag <= pwdata[`SRC_EE_FLAG] | src_ee_set;
      low_voltage_flag <= pwdata[`SRC_LV_FLAG] | src_lv_set;
      serial_module_enable <= pwdata[`SRC_SM_EN];
      ext_periph_enable <= pwdata[`SRC_XP_EN];
      eeprom_done_enable <= pwdata[`SRC_EE_EN];
      low_voltage_enable <= pwdata[`SRC_LV_EN];
    end else begin
      serial_module_flag <= serial_module_flag | src_sm_set;
      ext_periph_flag <= ext_periph_flag | src_xp_set;
      eeprom_done_flag <= eeprom_done_flag | src_ee_set;
      low_voltage_flag <= low_voltage_flag | src_lv_set;
    end
  end

  // Shared groups: a grant clears its own flag, a new event still sets.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_request_flags <= 6'h00;
      shared_enable <= 6'h00;
    end else if (wr_shared) begin
      shared_enable <= pwdata[5:0];
      shared_request_flags <= (pwdata[`SH_FLAG_LO+5:`SH_FLAG_LO] &
                               ~shared_taken) | group_event;
    end else begin
      shared_request_flags <= (shared_request_flags & ~shared_taken) |
                              group_event;
    end
  end

  // Periodic enables and flags; an overflow beats any clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period0_irq_enable <= 1'b0;
      period1_irq_enable <= 1'b0;
      period0_request_flag <= 1'b0;
      period1_request_flag <= 1'b0;
    end else if (wr_core) begin
      period0_irq_enable <= pwdata[`CC_P0_EN];
      period1_irq_enable <= pwdata[`CC_P1_EN];
      period0_request_flag <= (pwdata[`CC_P0_FLAG] & ~take_p0) | p0_ovf;
      period1_request_flag <= (pwdata[`CC_P1_FLAG] & ~take_p1) | p1_ovf;
    end else begin
      period0_request_flag <= (period0_request_flag & ~take_p0) |
                              p0_ovf;
      period1_request_flag <= (period1_request_flag & ~take_p1) |
                              p1_ovf;
    end
  end

  // Global enable: the grant clear outranks return and software write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0;
    end else if (take) begin
      global_irq_enable <= 1'b0;
    end else if (ret_from_irq) begin
      global_irq_enable <= 1'b1;
    end else if (wr_core) begin
      global_irq_enable <= pwdata[`CC_GIE];
    end
  end

  // Request holds its vector until the core takes it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= 1'b0;
      irq_vector <= `VEC_NONE;
    end else if (take) begin
      irq_req <= 1'b0;
    end else if (!irq_req && ok_to_grant && next_vector != `VEC_NONE) begin
      irq_req <= 1'b1;
      irq_vector <= next_vector;
    end
  end

  // Read words; reserved bits read as zero.
  wire [31:0] src_word = {24'h000000, eeprom_done_flag, low_voltage_flag,
                          ext_periph_flag, serial_module_flag,
                          eeprom_done_enable, low_voltage_enable,
                          ext_periph_enable, serial_module_enable};
  wire [31:0] shared_word = {18'h00000, shared_request_flags, 2'b00,
                             shared_enable};
  wire [31:0] core_word = {27'h0000000, period1_request_flag,
                           period0_request_flag, period1_irq_enable,
                           period0_irq_enable, global_irq_enable};
  wire [31:0] status_word = {27'h0000000, irq_req, irq_vector};

  // Read data is registered in the setup cycle, so the access phase never
  // waits; the word stands until the next read setup.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en && !penable) begin
      if (at_ofs(paddr, `OFS_PERIOD_CTRL)) begin
        prdata <= {24'h000000, period_ctrl};
      end else if (at_ofs(paddr, `OFS_SRC_CTRL)) begin
        prdata <= src_word;
      end else if (at_ofs(paddr, `OFS_SHARED_CTRL)) begin
        prdata <= shared_word;
      end else if (at_ofs(paddr, `OFS_CORE_CTRL)) begin
        prdata <= core_word;
      end else if (mapped(paddr)) begin
        prdata <= status_word;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule // irq_block

/* File: irq_block_properties.sv */
/* Port-level checker for irq_block.
   Bound to every irq_block instance; sees only its ports. */
`timescale 1ns/1ps
`include "irq_defines.vh"
module irq_block_properties (
  // APB.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Core side.
  input wire stack_full,
  input wire core_ack,
  input wire ret_from_irq,
  input wire irq_req,
  input wire [3:0] irq_vector,
  input wire slow_crystal_low_power
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_setup = psel && !penable && !pwrite;
  wire ctl_wr = psel && penable && pwrite && paddr == `OFS_PERIOD_CTRL;
  bus_answer_a: assert property (pready && !pslverr)
    else $error("bus answer not ready or in error");
  stack_block_a: assert property ($rose(irq_req) |-> !$past(stack_full))
    else $error("request raised under a full stack");
  req_hold_a: assert property (irq_req && !core_ack |=> irq_req)
    else $error("request dropped before the core took it");
  vec_range_a: assert property (irq_req |-> irq_vector inside {[1:8]})
    else $error("vector code out of range");
  vec_stable_a: assert property (irq_req && !core_ack |=> $stable(irq_vector))
    else $error("vector changed while pending");
  ack_clear_a: assert property (irq_req && core_ack && !ret_from_irq |=>
    !irq_req ##1 (!irq_req || $past(ret_from_irq)))
    else $error("request returned after service without return");
  low_power_a: assert property (ctl_wr |=> ##1
    slow_crystal_low_power == $past(pwdata[3], 2))
    else $error("low power output does not follow bit 3");
  unmapped_a: assert property (rd_setup && paddr == 12'h020 |=> prdata == 0)
    else $error("unmapped read not zero");
  status_read_a: assert property (rd_setup && paddr == `OFS_VECTOR |=>
    prdata[4:0] == {$past(irq_req), $past(irq_vector)})
    else $error("status read does not match request state");
endmodule // irq_block_properties
bind irq_block irq_block_properties u_props (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .stack_full, .core_ack, .ret_from_irq, .irq_req, .irq_vector,
  .slow_crystal_low_power);

/* File: core_model.sv */
/* Processor core stand-in that takes each pending request.
   Assumes irq_req holds until core_ack. */
`timescale 1ns/1ps
module core_model (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // Request handshake.
  input wire irq_req,
  output reg core_ack
);
  reg [1:0] wait_cnt;
  // The pause lets the bench read the vector before it is taken.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 2'h0;
      core_ack <= 1'b0;
    end else begin
      // Taking a request never touches any source flag.
      core_ack <= irq_req && !core_ack && wait_cnt == 2'h2;
      wait_cnt <= (irq_req && !core_ack) ? wait_cnt + 2'h1 : 2'h0;
    end
  end
endmodule // core_model

/* File: multifunction_and_timebase_irq_tb_top.sv */
/* Self-checking bench for irq_block over APB.
   Assumes core_model answers every request. */
`timescale 1ns/1ps
module multifunction_and_timebase_irq_tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [9:0] ev = 10'h0;
  reg [1:0] tclk_cnt = 2'h0;
  reg stack_full = 1'b0;
  reg ret_from_irq = 1'b0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire core_ack;
  wire irq_req;
  wire [3:0] irq_vector;
  wire slow_crystal_low_power;
  integer err_total = 0;
  integer tests_run = 0;
  integer i;
  integer n;
  reg [31:0] q;
  always #20 pclk = ~pclk;
  // Slow dedicated clock at a quarter of pclk.
  always @(posedge pclk) tclk_cnt <= tclk_cnt + 2'h1;
  irq_block uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serial_byte_done(ev[0]),
    .eeprom_cycle_done(ev[1]), .low_voltage_event(ev[2]),
    .periph_irq_pin(!ev[3]), .timer_event(ev[9:4]),
    .dedicated_period_clock(tclk_cnt[1]), .stack_full, .core_ack,
    .ret_from_irq, .irq_req, .irq_vector, .slow_crystal_low_power);
  core_model partner (.pclk, .presetn, .irq_req, .core_ack);
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("Checks %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  task stall;
    begin
      err_total = err_total + 1;
      close_out;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) stall;
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      check(q, e);
    end
  endtask
  task await(input lvl);
    begin
      n = 0;
      while (irq_req !== lvl && n < 20000) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n >= 20000) stall;
    end
  endtask
  task serve(input [3:0] v);
    begin
      await(1'b1);
      check({28'h0, irq_vector}, {28'h0, v});
      await(1'b0);
    end
  endtask
  task fire(input integer k);
    begin
      ev <= 10'h1 << k;
      @(posedge pclk);
      ev <= 10'h0;
      @(posedge pclk);
    end
  endtask
  task back;
    begin
      ret_from_irq <= 1'b1;
      @(posedge pclk);
      ret_from_irq <= 1'b0;
      @(posedge pclk);
    end
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h37);
    apb(1'b1, 12'h020, 32'hFF);
    rd(12'h020, 32'h0);
    rd(12'h010, 32'h0);
    $display("Reset test done");
    apb(1'b1, 12'h004, 32'h0F);
    apb(1'b1, 12'h008, 32'h3F);
    apb(1'b1, 12'h00C, 32'h1);
    for (i = 0; i < 4; i = i + 1) begin
      fire(i);
      serve(4'h1);
      rd(12'h004, (i == 0 ? 32'h10 : i == 1 ? 32'h80 :
        i == 2 ? 32'h40 : 32'h20) | 32'h0F);
      rd(12'h008, 32'h3F);
      rd(12'h00C, 32'h0);
      apb(1'b1, 12'h004, 32'h0F);
      back;
      rd(12'h00C, 32'h1);
    end
    $display("Source test done");
    for (i = 5; i < 10; i = i + 1) begin
      stack_full <= (i == 7);
      fire(i);
      if (i == 7) begin
        repeat (30) @(posedge pclk);
        check({31'h0, irq_req}, 32'h0);
        stack_full <= 1'b0;
      end
      serve(i - 3);
      back;
    end
    apb(1'b1, 12'h00C, 32'h0);
    fire(6);
    repeat (30) @(posedge pclk);
    check({31'h0, irq_req}, 32'h0);
    rd(12'h008, 32'h43F);
    apb(1'b1, 12'h00C, 32'h1);
    serve(4'h3);
    back;
    $display("Group test done");
    apb(1'b1, 12'h00C, 32'h3);
    apb(1'b1, 12'h000, 32'hC8);
    repeat (2) @(posedge pclk);
    check({31'h0, slow_crystal_low_power}, 32'h1);
    await(1'b1);
    check({31'h0, n > 990 && n < 1060}, 32'h1);
    check({28'h0, irq_vector}, 32'h7);
    await(1'b0);
    rd(12'h00C, 32'h2);
    back;
    apb(1'b1, 12'h00C, 32'h5);
    serve(4'h8);
    apb(1'b1, 12'h000, 32'h40);
    apb(1'b1, 12'h00C, 32'h3);
    repeat (1200) @(posedge pclk);
    check({31'h0, irq_req}, 32'h0);
    apb(1'b1, 12'h000, 32'h80);
    await(1'b1);
    check({31'h0, n > 990 && n < 1060}, 32'h1);
    check({28'h0, irq_vector}, 32'h7);
    await(1'b0);
    $display("Period test done");
    close_out;
  end
endmodule // multifunction_and_timebase_irq_tb_top
